// ==== include/acs_regs.vh ====
// Register map, field positions, reset values and phase timing
// for the converter autosequencer.
// Assumes a 16-bit word-addressed register port and a 40 MHz clock.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ----------------------------------------
// Register addresses (word addresses)
// ----------------------------------------
`define ACS_ADDR_CTRL 16'h70a1
`define ACS_ADDR_LIMIT 16'h70a2
`define ACS_ADDR_SLOT0 16'h70a3
`define ACS_ADDR_SLOT1 16'h70a4
`define ACS_ADDR_SLOT2 16'h70a5
`define ACS_ADDR_SLOT3 16'h70a6
`define ACS_ADDR_STAT 16'h70a7
`define ACS_ADDR_RES0 16'h70a8
`define ACS_ADDR_RES15 16'h70b7

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ACS_CTL_CASC 0
`define ACS_CTL_CPS 1
`define ACS_CTL_APS_LO 2
`define ACS_CTL_APS_HI 5
`define ACS_CTL_GO1 6
`define ACS_CTL_GO2 7
`define ACS_CTL_RST2 8
`define ACS_CTL_BUSY1 9
`define ACS_CTL_BUSY2 10

// ----------------------------------------
// Limit register fields
// ----------------------------------------
`define ACS_LIM1_HI 3
`define ACS_LIM1_LO 0
`define ACS_LIM2_HI 6
`define ACS_LIM2_LO 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACS_RST_WORD 16'h0000
`define ACS_RST_CFG 6'h00
`define ACS_RST_LIM 7'h00

// ----------------------------------------
// Phase lengths in clock cycles, prescale clear
// ----------------------------------------
`define ACS_SYNC_CYC 7'd2
`define ACS_ACQ_BASE 7'd2
`define ACS_CONV_CYC 7'd10
`define ACS_EOC_CYC 7'd1
`define ACS_EOS_CYC 7'd1

`endif

// ==== verilog/acs_core.v ====
// Autosequencer for a 16-input multiplexed 10-bit converter: slot
// registers, remaining count, status, result buffer and phase timer.
// Assumes a single 40 MHz clock; converter result bits arrive from
// the analog core asynchronously and are resynchronised here.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "acs_regs.vh"

// Overview of operation
// - Dual first sequencer wraps slot 7 to 0
// - Limit field means value plus one conversions
// - One remaining count shared by all sequencers
// - Remaining count loaded from limit at start
// - Remaining count means value plus one left
// - Count plus busy bits identify progress
// - Status bits 6-4 show second sequencer slot
// - Status bits 3-0 show first sequencer slot
// - Sixteen 4-bit slots, four per register
// - Slot value selects that analog input
// - Cascaded results 9-16 land in 8-15
// - Results left-justified, low six bits zero
// - Sync first only, end flag last only
// - Prescale clear lengths 2,2,10,1,1
// - Prescale set lengths 2or3,4,20,2,1
// - Acquisition grows linearly with window scale
// - Sessions start at initial slot, in order
// - Second sequencer starts and resets at 8
module acs_core (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [9:0] conv_data_i,
  output reg [15:0] rdata_o,
  output reg [3:0] mux_sel_o,
  output reg sample_o,
  output reg convert_o,
  output reg eos_o,
  output reg busy1_o,
  output reg busy2_o
);

  // ----------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_SYNC = 6'h02;
  localparam [5:0] ST_ACQ = 6'h04;
  localparam [5:0] ST_CONV = 6'h08;
  localparam [5:0] ST_EOC = 6'h10;
  localparam [5:0] ST_EOS = 6'h20;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg casc; // Cascaded mode when set
  reg clock_prescale_select; // Clock prescale select
  reg [3:0] aps; // Acquisition window scale
  reg [6:0] limit; // Both conversion limits
  reg [15:0] slot_reg [0:3]; // Channel slot words
  reg [9:0] res_mem [0:15]; // Result buffer, no reset needed
  reg [5:0] state; // Shared converter state
  reg [6:0] cnt; // Phase cycles left minus one
  reg act2; // Second sequencer owns converter
  reg [3:0] ptr1; // First sequencer slot
  reg [2:0] ptr2; // Second sequencer slot less eight
  reg [3:0] rem; // Remaining conversions minus one
  reg pend1; // First start pending
  reg pend2; // Second start pending
  reg div_ph; // Converter clock phase, halved rate
  reg [9:0] cd_s1; // Result sync, first stage
  reg [9:0] cd_s2; // Result sync, second stage

  // ----------------------------------------
  // Decoded strobes
  // ----------------------------------------
  wire wr_ctrl = wr_i && (addr_i == `ACS_ADDR_CTRL);
  wire wr_lim = wr_i && (addr_i == `ACS_ADDR_LIMIT);
  wire go1_w = wr_ctrl && wdata_i[`ACS_CTL_GO1];
  // Second start is ignored in cascaded mode
  wire go2_w = wr_ctrl && wdata_i[`ACS_CTL_GO2] && !casc;
  wire rst2_w = wr_ctrl && wdata_i[`ACS_CTL_RST2];
  wire idle = (state == ST_IDLE);
  wire abort2 = rst2_w && act2 && !idle;
  wire done = (cnt == 7'd0);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Phase length in cycles for the state being entered
  function [6:0] acs_len;
    input [5:0] ph;
    input c;
    input [3:0] s;
    reg [6:0] b;
    begin
      b = 7'd0;
      case (ph)
        ST_ACQ: begin
          b = `ACS_ACQ_BASE + {2'b00, s, 1'b0};
        end
        ST_CONV: begin
          b = `ACS_CONV_CYC;
        end
        ST_EOC: begin
          b = `ACS_EOC_CYC;
        end
        default: begin
          b = `ACS_EOS_CYC;
        end
      endcase
      // halved converter clock doubles work phases
      if (c && (ph != ST_EOS)) begin
        acs_len = {b[5:0], 1'b0};
      end else begin
        acs_len = b;
      end
    end
  endfunction

  // Buffer index of a sequencer position
  function [3:0] acs_idx;
    input second;
    input cas;
    input [3:0] p1;
    input [2:0] p2;
    begin
      if (second) begin
        // second sequencer lives at slots 8-15
        acs_idx = {1'b1, p2};
      end else if (cas) begin
        acs_idx = p1;
      end else begin
        acs_idx = {1'b0, p1[2:0]};
      end
    end
  endfunction

  // Channel held in a slot
  function [3:0] acs_chan;
    input [3:0] idx;
    reg [15:0] w;
    begin
      w = slot_reg[idx[3:2]];
      // lowest slot in least significant nibble
      acs_chan = w[{idx[1:0], 2'b00} +: 4];
    end
  endfunction

  wire [3:0] cur_idx = acs_idx(act2, casc, ptr1, ptr2);
  // dual mode wraps the first pointer past seven
  wire [3:0] nxt_p1 = casc ? ptr1 + 4'h1 : {1'b0, ptr1[2:0] + 3'h1};
  wire [2:0] nxt_p2 = ptr2 + 3'h1;
  wire [3:0] nxt_idx = acs_idx(act2, casc, nxt_p1, nxt_p2);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Software writes to control, limit and slot words
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      casc <= 1'b0;
      clock_prescale_select <= 1'b0;
      aps <= 4'h0;
      limit <= `ACS_RST_LIM;
      slot_reg[0] <= `ACS_RST_WORD;
      slot_reg[1] <= `ACS_RST_WORD;
      slot_reg[2] <= `ACS_RST_WORD;
      slot_reg[3] <= `ACS_RST_WORD;
    end else begin
      if (wr_ctrl) begin
        casc <= wdata_i[`ACS_CTL_CASC];
        clock_prescale_select <= wdata_i[`ACS_CTL_CPS];
        aps <= wdata_i[`ACS_CTL_APS_HI:`ACS_CTL_APS_LO];
      end
      if (wr_lim) begin
        limit <= wdata_i[6:0];
      end
      if (wr_i && (addr_i >= `ACS_ADDR_SLOT0) && (addr_i <= `ACS_ADDR_SLOT3)) begin
        slot_reg[addr_i[1:0] + 2'b01] <= wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Converter clock phase and result sync
  // ----------------------------------------
  // Free-running divide by two stands in for the converter clock
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_ph <= 1'b0;
      cd_s1 <= 10'h000;
      cd_s2 <= 10'h000;
    end else begin
      div_ph <= ~div_ph;
      cd_s1 <= conv_data_i;
      cd_s2 <= cd_s1;
    end
  end

  // ----------------------------------------
  // Start requests
  // ----------------------------------------
  // A new request wins over the clear that a start performs
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend1 <= 1'b0;
      pend2 <= 1'b0;
    end else begin
      pend1 <= go1_w | (pend1 & ~idle);
      // Second start only taken when first is not waiting;
      // a start written beside the reset bit still stands
      pend2 <= go2_w | (pend2 & ~rst2_w & ~(idle & ~pend1));
    end
  end

  // ----------------------------------------
  // Sequencer and phase timer
  // ----------------------------------------
  // One converter shared; first sequencer has priority
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      cnt <= 7'd0;
      act2 <= 1'b0;
      // counter and state fields reset to zero
      ptr1 <= 4'h0;
      ptr2 <= 3'h0;
      rem <= 4'h0;
      mux_sel_o <= 4'h0;
    end else if (abort2) begin
      // abort back to slot eight, waiting
      state <= ST_IDLE;
      cnt <= 7'd0;
      ptr2 <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pend1) begin
            act2 <= 1'b0;
            ptr1 <= 4'h0;
            rem <= casc ? limit[`ACS_LIM1_HI:`ACS_LIM1_LO] :
                   limit[`ACS_LIM1_HI:`ACS_LIM1_LO];
            // slot value is the input number
            mux_sel_o <= acs_chan(4'h0);
            // extra sync cycle off the converter clock
            cnt <= `ACS_SYNC_CYC - 7'd1 + {6'h00, clock_prescale_select & div_ph};
            state <= ST_SYNC;
          end else if (pend2 && !casc) begin
            act2 <= 1'b1;
            // second sequencer begins at slot eight
            ptr2 <= 3'h0;
            // second limit is three bits wide
            rem <= {1'b0, limit[`ACS_LIM2_HI:`ACS_LIM2_LO]};
            mux_sel_o <= acs_chan(4'h8);
            cnt <= `ACS_SYNC_CYC - 7'd1 + {6'h00, clock_prescale_select & div_ph};
            state <= ST_SYNC;
          end
        end
        // sync only ahead of the first conversion
        ST_SYNC: begin
          if (done) begin
            cnt <= acs_len(ST_ACQ, clock_prescale_select, aps) - 7'd1;
            state <= ST_ACQ;
          end else begin
            cnt <= cnt - 7'd1;
          end
        end
        ST_ACQ: begin
          if (done) begin
            cnt <= acs_len(ST_CONV, clock_prescale_select, aps) - 7'd1;
            state <= ST_CONV;
          end else begin
            cnt <= cnt - 7'd1;
          end
        end
        ST_CONV: begin
          if (done) begin
            cnt <= acs_len(ST_EOC, clock_prescale_select, aps) - 7'd1;
            state <= ST_EOC;
          end else begin
            cnt <= cnt - 7'd1;
          end
        end
        ST_EOC: begin
          if (!done) begin
            cnt <= cnt - 7'd1;
          end else if (rem == 4'h0) begin
            // end flag cycle after the last only
            cnt <= acs_len(ST_EOS, clock_prescale_select, aps) - 7'd1;
            state <= ST_EOS;
          end else begin
            // one fewer left per finished conversion
            rem <= rem - 4'h1;
            // step to next slot in order
            if (act2) begin
              ptr2 <= nxt_p2;
            end else begin
              ptr1 <= nxt_p1;
            end
            mux_sel_o <= acs_chan(nxt_idx);
            cnt <= acs_len(ST_ACQ, clock_prescale_select, aps) - 7'd1;
            state <= ST_ACQ;
          end
        end
        ST_EOS: begin
          if (done) begin
            // busy drops after the final conversion
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 7'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  // Captured on the last EOC cycle, in slot order
  always @(posedge clk_i) begin
    if ((state == ST_EOC) && done && !abort2) begin
      res_mem[cur_idx] <= cd_s2;
    end
  end

  // ----------------------------------------
  // Converter-facing outputs
  // ----------------------------------------
  // Registered copies of the phase, one cycle behind the state
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sample_o <= 1'b0;
      convert_o <= 1'b0;
      eos_o <= 1'b0;
      busy1_o <= 1'b0;
      busy2_o <= 1'b0;
    end else begin
      sample_o <= (state == ST_ACQ);
      convert_o <= (state == ST_CONV);
      eos_o <= (state == ST_EOS) && done;
      // busy bits pair with the shared count
      busy1_o <= !idle && !act2;
      busy2_o <= !idle && act2 && !abort2;
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Data stand in the cycle after the read strobe
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= `ACS_RST_WORD;
    end else if (rd_i) begin
      if (addr_i == `ACS_ADDR_CTRL) begin
        rdata_o <= {5'h00, busy2_o, busy1_o, 3'h0, aps, clock_prescale_select, casc};
      end else if (addr_i == `ACS_ADDR_LIMIT) begin
        rdata_o <= {9'h000, limit};
      end else if ((addr_i >= `ACS_ADDR_SLOT0) && (addr_i <= `ACS_ADDR_SLOT3)) begin
        rdata_o <= slot_reg[addr_i[1:0] + 2'b01];
      end else if (addr_i == `ACS_ADDR_STAT) begin
        // one count field shared by both sequencers
        rdata_o <= {4'h0, rem, 1'b0, ptr2, ptr1};
      end else if ((addr_i >= `ACS_ADDR_RES0) && (addr_i <= `ACS_ADDR_RES15)) begin
        rdata_o <= {res_mem[addr_i[3:0] - 4'h8], 6'h00};
      end else begin
        // Unmapped addresses read as zero
        rdata_o <= `ACS_RST_WORD;
      end
    end else begin
      rdata_o <= `ACS_RST_WORD;
    end
  end

endmodule // acs_core

// ==== test/acs_analog_model.sv ====
// Stand-in for the analog mux and sample-and-convert core.
// Assumes the core drives the channel number and the sample strobe.
`timescale 1ns/1ps
module acs_analog_model (
  input wire clk_i,
  input wire [3:0] mux_sel_i,
  input wire sample_i,
  output reg [9:0] conv_data_o = 10'h000
);
  // ----
  // Code per channel: input number on top, fixed marker below
  // ----
  // code names its input
  always @(posedge clk_i) begin
    // Inverse while sampling, so a too-early capture shows up
    if (sample_i) begin
      conv_data_o <= ~{mux_sel_i, 6'h15};
    end else begin
      conv_data_o <= {mux_sel_i, 6'h15};
    end
  end
endmodule // acs_analog_model

// ==== test/acs_checker.sv ====
// Port-level checker for the converter autosequencer.
// Assumes one clock domain and the register map header.
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_checker (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  input wire [3:0] mux_sel_o,
  input wire sample_o,
  input wire convert_o,
  input wire eos_o,
  input wire busy1_o,
  input wire busy2_o
);
  // ----
  // Config mirror and run counters
  // ----
  reg clock_prescale_select; // Prescale copy
  reg [3:0] scl; // Window scale copy
  reg [6:0] n_s; // Acquisition run
  reg [6:0] n_c; // Convert run
  wire [6:0] acq_len = (7'd2 + {2'b00, scl, 1'b0}) << clock_prescale_select; // Expected window
  // Mirror trusts that config is not rewritten mid-session
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clock_prescale_select <= 1'b0;
      scl <= 4'h0;
      n_s <= 7'h00;
      n_c <= 7'h00;
    end else begin
      if (wr_i && addr_i == `ACS_ADDR_CTRL) begin
        clock_prescale_select <= wdata_i[1];
        scl <= wdata_i[5:2];
      end
      n_s <= sample_o ? n_s + 7'd1 : 7'h00;
      n_c <= convert_o ? n_c + 7'd1 : 7'h00;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_go1;
    wr_i && addr_i == `ACS_ADDR_CTRL && wdata_i[6] && !wdata_i[1] && !busy1_o && !busy2_o;
  endsequence
  sequence s_slot_rb;
    wr_i && addr_i >= `ACS_ADDR_SLOT0 && addr_i <= `ACS_ADDR_SLOT3
      ##2 rd_i && addr_i == $past(addr_i, 2);
  endsequence
  property p_start;
    s_go1 |-> ##3 busy1_o;
  endproperty
  a_start: assert property (p_start) else $error("busy late after start");
  property p_acq_len;
    $fell(sample_o) |-> n_s == acq_len;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition length");
  property p_conv_len;
    $fell(convert_o) |-> n_c == (clock_prescale_select ? 7'd20 : 7'd10);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("convert length");
  property p_acq_conv;
    $fell(sample_o) |-> convert_o && !sample_o;
  endproperty
  a_acq_conv: assert property (p_acq_conv) else $error("convert not after acq");
  property p_mux_hold;
    convert_o |-> $stable(mux_sel_o);
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("input moved in convert");
  property p_eos_end;
    $fell(busy1_o) |-> $past(eos_o) && !eos_o;
  endproperty
  a_eos_end: assert property (p_eos_end) else $error("end without end flag");
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_stat_rsv;
    rd_i && addr_i == `ACS_ADDR_STAT |=> rdata_o[15:12] == 4'h0 && !rdata_o[7];
  endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits");
  property p_slot_rb;
    s_slot_rb |=> rdata_o == $past(wdata_i, 3);
  endproperty
  a_slot_rb: assert property (p_slot_rb) else $error("slot readback");
endmodule // acs_checker

bind acs_core acs_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mux_sel_o(mux_sel_o),
  .sample_o(sample_o), .convert_o(convert_o), .eos_o(eos_o), .busy1_o(busy1_o),
  .busy2_o(busy2_o));

// ==== test/tb_acs_core.sv ====
// Self-checking bench for the converter autosequencer.
// Assumes the analog stand-in and the register map header.
`timescale 1ns/1ps
`include "acs_regs.vh"
module tb_acs_core;
  reg clk_i = 1'b0; // 40 MHz
  reg sys_rst_i = 1'b1; // Held 12 cycles
  reg [15:0] addr_i = 16'h0000;
  reg [15:0] wdata_i = 16'h0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  wire [9:0] conv_data; // Analog result bits
  wire [15:0] rdata_o;
  wire [3:0] mux_sel_o;
  wire sample_o, convert_o, eos_o, busy1_o, busy2_o;
  integer n_mismatch = 0;
  integer samples_checked = 0;
  integer i;
  reg [31:0] seed = 32'hca9e0d11;
  reg [3:0] slot [0:15]; // Slot copy
  logic [15:0] eq[$], mq[$]; // Read notes
  logic [3:0] xq[$]; // Input order notes
  reg rd_q = 1'b0;
  reg cv_q = 1'b0;
  always #12.5 clk_i = ~clk_i;
  acs_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .conv_data_i(conv_data), .rdata_o(rdata_o),
    .mux_sel_o(mux_sel_o), .sample_o(sample_o), .convert_o(convert_o), .eos_o(eos_o),
    .busy1_o(busy1_o), .busy2_o(busy2_o));
  acs_analog_model u_ana (.clk_i(clk_i), .mux_sel_i(mux_sel_o), .sample_i(sample_o),
    .conv_data_o(conv_data));
  // ----
  // Helpers
  // ----
  function automatic [31:0] xs(input [31:0] v);
    reg [31:0] x;
    begin
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task cmp_val(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cmp_rd(input [15:0] got, input [15:0] exp, input [15:0] m);
    cmp_val(got & m, exp & m);
  endtask
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [15:0] e, input [15:0] m);
    begin
      eq.push_back(e);
      mq.push_back(m);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
    end
  endtask
  // Session: start, read status early, time the busy level
  task run(input [15:0] c, input [15:0] l, input [15:0] d, input b2, input [15:0] st);
    integer t;
    begin
      wr(`ACS_ADDR_LIMIT, l);
      wr(`ACS_ADDR_CTRL, c);
      t = 0;
      while (!(b2 ? busy2_o : busy1_o) && t < 20) begin
        @(posedge clk_i);
        t = t + 1;
      end
      rd(`ACS_ADDR_STAT, st, b2 ? 16'h0f70 : 16'h0f0f);
      t = 2;
      while ((b2 ? busy2_o : busy1_o) && t < 2000) begin
        @(posedge clk_i);
        t = t + 1;
      end
      // Prescaled sync may take one extra cycle
      if (c[1] && t == d + 1) t = d;
      cmp_val(t[15:0], d);
    end
  endtask
  task results;
    begin
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ----
  // Output watcher
  // ----
  always @(posedge clk_i) begin
    if (rd_q) cmp_rd(rdata_o, eq.pop_front(), mq.pop_front());
    rd_q <= rd_i;
    if (convert_o && !cv_q) cmp_val({12'h000, mux_sel_o}, {12'h000, xq.pop_front()});
    cv_q <= convert_o;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch = n_mismatch + 1;
    results;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wr(`ACS_ADDR_STAT, 16'hffff);
    for (i = 0; i < 5; i = i + 1) rd(`ACS_ADDR_SLOT0 + i[15:0], 16'h0000, 16'h0f7f);
    rd(16'h70b8, 16'h0000, 16'hffff);
    rd(16'h70a0, 16'h0000, 16'hffff);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      wr(`ACS_ADDR_SLOT0 + i[15:0], seed[15:0]);
      {slot[4*i+3], slot[4*i+2], slot[4*i+1], slot[4*i]} = seed[15:0];
      rd(`ACS_ADDR_SLOT0 + i[15:0], seed[15:0], 16'hffff);
    end
    // Cascaded, sixteen conversions
    for (i = 0; i < 16; i = i + 1) xq.push_back(slot[i]);
    run(16'h0041, 16'h000f, 16'd211, 1'b0, 16'h0f00);
    for (i = 0; i < 16; i = i + 1)
      rd(`ACS_ADDR_RES0 + i[15:0], {slot[i], 6'h15, 6'h00}, 16'hffff);
    // Second start is ignored while cascaded
    wr(`ACS_ADDR_CTRL, 16'h0081);
    repeat (2) rd(`ACS_ADDR_CTRL, 16'h0001, 16'h0603);
    // Dual first sequencer past slot 7
    for (i = 0; i < 10; i = i + 1) xq.push_back(slot[i % 8]);
    run(16'h0040, 16'h0009, 16'd133, 1'b0, 16'h0900);
    // Second sequencer from slot 8
    for (i = 8; i < 11; i = i + 1) xq.push_back(slot[i]);
    run(16'h0080, 16'h0020, 16'd42, 1'b1, 16'h0200);
    // Abort second before its first convert
    wr(`ACS_ADDR_LIMIT, 16'h0070);
    wr(`ACS_ADDR_CTRL, 16'h0080);
    wr(`ACS_ADDR_CTRL, 16'h0100);
    rd(`ACS_ADDR_CTRL, 16'h0000, 16'h0400);
    xq.push_back(slot[8]);
    run(16'h0080, 16'h0000, 16'd16, 1'b1, 16'h0000);
    // Prescale and window scale corners, one conversion
    for (i = 0; i < 4; i = i + 1) begin
      xq.push_back(slot[0]);
      run(16'h0040 | (i[1] ? 16'h003c : 16'h0000) | (i[0] ? 16'h0002 : 16'h0000), 16'h0000,
        i[0] ? (i[1] ? 16'd89 : 16'd29) : (i[1] ? 16'd46 : 16'd16), 1'b0, 16'h0000);
    end
    repeat (3) @(posedge clk_i);
    results;
  end
endmodule // tb_acs_core
